// ===== design/ffb_top.sv
// Eight-stage over/under frequency protection with event output.
// Assumes frequency words arrive on this clock; block input is a pin.
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module ffb_top #(
  parameter int MS_CYC = ffb_pkg::MS_CYCLES
) (
  input wire logic clk_sys, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic [15:0] freq1_hz, // First voltage input, 0.01 Hz units
  input wire logic freq1_vld, // New first input frequency
  input wire logic [15:0] freq2_hz, // Second voltage input, 0.01 Hz units
  input wire logic freq2_vld, // New second input frequency
  input wire logic blk_in, // Block from blocking matrix
  input wire logic [7:0] addr, // Register byte address
  input wire logic [31:0] wdata, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  output logic [31:0] rdata, // Read data, cycle after strobe
  output logic [7:0] start_o, // Start per stage
  output logic [7:0] trip_o, // Trip per stage
  output logic [7:0] blocked_o, // Blocked per stage
  output ffb_pkg::ffb_event_t ev_o, // Event record
  output logic ev_vld, // Event pulse
  output logic irq // Level interrupt
);

  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------
  // Two-bit field of a per-stage setting word
  function automatic logic [1:0] fld2(input logic [15:0] v,
                                      input logic [2:0] i);
    fld2 = v[{i, 1'b0} +: 2];
  endfunction

  // Pick-up compare with drop-out margin once held
  function automatic logic picked(input logic over, input logic [15:0] f,
                                  input logic [15:0] pk, input logic held);
    logic r;
    r = 1'b0;
    if (over) begin
      r = held ? (f > pk - ffb_pkg::HYST_UNITS) : (f > pk);
    end else begin
      r = held ? (f < pk + ffb_pkg::HYST_UNITS) : (f < pk);
    end
    picked = r;
  endfunction

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  ffb_pkg::ffb_ctrl_t ctrl_r;
  logic [15:0] en_r, force_r;
  logic [5:0] sgi_r;
  logic [15:0] pk_mem [64];
  logic [20:0] dly_mem [64];
  logic [63:0] use_mem;
  logic [2:0] stat_r, mask_r, stat_set;
  logic [31:0] cnt_s_r, cnt_t_r, cnt_b_r, ms_cnt_r;
  logic [31:0] div_r;
  logic tick;
  logic blk_s1_r, blk_s2_r, blk_s3_r, blk_lvl_r, blk_cyc_r;
  logic [15:0] f1_r, f2_r, f_sel;
  logic [3:0] age_r;
  logic meas_ok;
  ffb_pkg::ffb_state_t state_r;
  logic [2:0] idx_r;
  logic [7:0] start_r, trip_r, blocked_r, pick_r;
  logic [20:0] tm_r [8];
  logic clr_req;
  logic inst_r;

  // Combinational view of the stage under scan
  logic [5:0] k_c;
  logic [15:0] pk_c;
  logic [20:0] dly_c, tm_n;
  logic [2:0] nm_c;
  logic [1:0] fc_c;
  logic en_c, blk_c, force_act, pick_c, s_n, t_n, b_n;
  logic [2:0] chg_c;

  assign clr_req = wr_en && addr == ffb_pkg::ADR_CTRL && wdata[ffb_pkg::C_CLR];
  assign start_o = start_r;
  assign trip_o = trip_r;
  assign blocked_o = blocked_r;

  // -------------------------------------------------------------------
  // Program cycle and time stamp
  // -------------------------------------------------------------------
  // One tick per millisecond paces both scanning and the stamp clock
  always_ff @(posedge clk_sys) begin
    if (srst || tick) begin
      div_r <= 32'h0;
    end else begin
      div_r <= div_r + 32'h1;
    end
  end
  assign tick = div_r == 32'(MS_CYC - 1);

  // Millisecond stamp counter
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ms_cnt_r <= 32'h0;
    end else if (tick) begin
      ms_cnt_r <= ms_cnt_r + 32'h1;
    end
  end

  // -------------------------------------------------------------------
  // Block input
  // -------------------------------------------------------------------
  // Three-stage sync; level moves only when second and third agree
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      blk_s1_r <= 1'b0;
      blk_s2_r <= 1'b0;
      blk_s3_r <= 1'b0;
      blk_lvl_r <= 1'b0;
      blk_cyc_r <= 1'b0;
    end else begin
      blk_s1_r <= blk_in;
      blk_s2_r <= blk_s1_r;
      blk_s3_r <= blk_s2_r;
      if (blk_s2_r == blk_s3_r) begin
        blk_lvl_r <= blk_s3_r;
      end
      if (tick) begin
        blk_cyc_r <= blk_lvl_r;
      end
    end
  end

  // -------------------------------------------------------------------
  // Frequency source
  // -------------------------------------------------------------------
  // Latest word per input; a stale selected source stops pick-up
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      f1_r <= 16'h0;
      f2_r <= 16'h0;
      age_r <= 4'hf;
    end else begin
      if (freq1_vld) begin
        f1_r <= freq1_hz;
      end
      if (freq2_vld) begin
        f2_r <= freq2_hz;
      end
      if (ctrl_r.src_sel ? freq2_vld : freq1_vld) begin
        age_r <= 4'h0;
      end else if (tick && age_r != 4'hf) begin
        age_r <= age_r + 4'h1;
      end
    end
  end
  assign f_sel = ctrl_r.src_sel ? f2_r : f1_r;
  assign meas_ok = age_r <= ffb_pkg::MEAS_MS;

  // -------------------------------------------------------------------
  // Scan sequencer
  // -------------------------------------------------------------------
  // Stages share one evaluator, visited in turn once per program cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_r <= ffb_pkg::FFB_IDLE;
      idx_r <= 3'h0;
    end else begin
      case (state_r)
        ffb_pkg::FFB_IDLE: begin
          idx_r <= 3'h0;
          if (tick) begin
            state_r <= ffb_pkg::FFB_SCAN;
          end
        end
        ffb_pkg::FFB_SCAN: begin
          idx_r <= idx_r + 3'h1;
          if (idx_r == 3'(ffb_pkg::N_STG - 1)) begin
            state_r <= ffb_pkg::FFB_IDLE;
          end
        end
        default: begin
          state_r <= ffb_pkg::FFB_IDLE;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------
  // Stage evaluator
  // -------------------------------------------------------------------
  // Settings of the active group; stages 0-3 over, 4-7 under
  always_comb begin
    k_c = {ctrl_r.sg_sel, idx_r};
    pk_c = pk_mem[k_c];
    dly_c = dly_mem[k_c];
    nm_c = ctrl_r.allow_node ? ctrl_r.node_mode : ffb_pkg::NM_ON;
    en_c = ctrl_r.func_on && use_mem[k_c] && nm_c != ffb_pkg::NM_OFF &&
           fld2(en_r, idx_r) == ffb_pkg::EN_YES;
    blk_c = blk_cyc_r || nm_c == ffb_pkg::NM_BLK ||
            nm_c == ffb_pkg::NM_TBLK;
    fc_c = fld2(force_r, idx_r);
    force_act = ctrl_r.force_en && fc_c != ffb_pkg::F_NORMAL;
    pick_c = en_c && meas_ok &&
             picked(!idx_r[2], f_sel, pk_c, pick_r[idx_r]);
    s_n = 1'b0;
    t_n = 1'b0;
    b_n = 1'b0;
    tm_n = 21'h0;
    if (force_act) begin
      s_n = fc_c == ffb_pkg::F_START || fc_c == ffb_pkg::F_TRIP;
      t_n = fc_c == ffb_pkg::F_TRIP;
      b_n = fc_c == ffb_pkg::F_BLOCKED;
    end else if (!pick_c) begin
      s_n = 1'b0;
    end else if (blk_c || blocked_r[idx_r]) begin
      b_n = 1'b1;
    end else begin
      s_n = 1'b1;
      if (dly_c == 21'h0) begin
        t_n = 1'b1;
      end else begin
        tm_n = trip_r[idx_r] ? tm_r[idx_r] : tm_r[idx_r] + 21'h1;
        t_n = trip_r[idx_r] || tm_n >= dly_c;
      end
    end
    chg_c = {b_n ^ blocked_r[idx_r], t_n ^ trip_r[idx_r],
             s_n ^ start_r[idx_r]};
  end

  // Stage outputs and delay timers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      start_r <= 8'h0;
      trip_r <= 8'h0;
      blocked_r <= 8'h0;
      pick_r <= 8'h0;
      for (int i = 0; i < ffb_pkg::N_STG; i++) begin
        tm_r[i] <= 21'h0;
      end
    end else if (state_r == ffb_pkg::FFB_SCAN) begin
      start_r[idx_r] <= s_n;
      trip_r[idx_r] <= t_n;
      blocked_r[idx_r] <= b_n;
      pick_r[idx_r] <= pick_c;
      tm_r[idx_r] <= tm_n;
    end
  end

  // -------------------------------------------------------------------
  // Events, counters, interrupt
  // -------------------------------------------------------------------
  // One record per stage carries all its changes under one stamp
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ev_vld <= 1'b0;
      ev_o <= '0;
      inst_r <= 1'b0;
    end else begin
      ev_vld <= state_r == ffb_pkg::FFB_SCAN && chg_c != 3'h0;
      inst_r <= !force_act && dly_c == 21'h0;
      if (state_r == ffb_pkg::FFB_SCAN) begin
        ev_o <= '{stage: idx_r, chg: chg_c, val: {b_n, t_n, s_n},
                  stamp: ms_cnt_r};
      end
    end
  end

  // ON edges of each output kind
  assign stat_set = (state_r == ffb_pkg::FFB_SCAN) ?
                    (chg_c & {b_n, t_n, s_n}) : 3'h0;

  // Clear request restarts counts; an ON in the same cycle still counts
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_s_r <= 32'h0;
      cnt_t_r <= 32'h0;
      cnt_b_r <= 32'h0;
    end else begin
      cnt_s_r <= (clr_req ? 32'h0 : cnt_s_r) +
                 32'(stat_set[ffb_pkg::O_START]);
      cnt_t_r <= (clr_req ? 32'h0 : cnt_t_r) +
                 32'(stat_set[ffb_pkg::O_TRIP]);
      cnt_b_r <= (clr_req ? 32'h0 : cnt_b_r) +
                 32'(stat_set[ffb_pkg::O_BLK]);
    end
  end

  // Sticky status, write one to clear; set beats clear
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stat_r <= 3'h0;
    end else if (wr_en && addr == ffb_pkg::ADR_IRQ_ST) begin
      stat_r <= (stat_r & ~wdata[2:0]) | stat_set;
    end else begin
      stat_r <= stat_r | stat_set;
    end
  end
  assign irq = |(stat_r & mask_r);

  // -------------------------------------------------------------------
  // Register port
  // -------------------------------------------------------------------
  // Static settings live outside the group store
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_r <= ffb_pkg::ffb_ctrl_t'(ffb_pkg::CTRL_RST);
      en_r <= ffb_pkg::EN_RST;
      force_r <= ffb_pkg::FORCE_RST;
      sgi_r <= 6'h0;
      mask_r <= 3'h0;
    end else if (wr_en) begin
      case (addr)
        ffb_pkg::ADR_CTRL: ctrl_r <= ffb_pkg::ffb_ctrl_t'(wdata[9:0]);
        ffb_pkg::ADR_EN: en_r <= wdata[15:0];
        ffb_pkg::ADR_FORCE: force_r <= wdata[15:0];
        ffb_pkg::ADR_SG_IDX: sgi_r <= wdata[5:0];
        ffb_pkg::ADR_IRQ_MSK: mask_r <= wdata[2:0];
        default: begin
        end
      endcase
    end
  end

  // Group store: pick-up, use flag and delay per group and stage
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      use_mem <= 64'h0;
      for (int i = 0; i < 64; i++) begin
        pk_mem[i] <= i[2] ? ffb_pkg::PK_UNDER_RST : ffb_pkg::PK_OVER_RST;
        dly_mem[i] <= ffb_pkg::DLY_RST;
      end
    end else if (wr_en && addr == ffb_pkg::ADR_SG_PK) begin
      pk_mem[sgi_r] <= wdata[15:0];
      use_mem[sgi_r] <= wdata[ffb_pkg::PK_USE];
    end else if (wr_en && addr == ffb_pkg::ADR_SG_DLY) begin
      dly_mem[sgi_r] <= wdata[20:0];
    end
  end

  // Read data for one cycle only; unmapped reads give zero
  always_ff @(posedge clk_sys) begin
    if (srst || !rd_en) begin
      rdata <= 32'h0;
    end else begin
      case (addr)
        ffb_pkg::ADR_CTRL: rdata <= {22'h0, ctrl_r};
        ffb_pkg::ADR_EN: rdata <= {16'h0, en_r};
        ffb_pkg::ADR_FORCE: rdata <= {16'h0, force_r};
        ffb_pkg::ADR_SG_IDX: rdata <= {26'h0, sgi_r};
        ffb_pkg::ADR_SG_PK: rdata <= {use_mem[sgi_r], 15'h0, pk_mem[sgi_r]};
        ffb_pkg::ADR_SG_DLY: rdata <= {11'h0, dly_mem[sgi_r]};
        ffb_pkg::ADR_STATUS: rdata <= {8'h0, blocked_r, trip_r, start_r};
        ffb_pkg::ADR_IRQ_ST: rdata <= {29'h0, stat_r};
        ffb_pkg::ADR_IRQ_MSK: rdata <= {29'h0, mask_r};
        ffb_pkg::ADR_CNT_S: rdata <= cnt_s_r;
        ffb_pkg::ADR_CNT_T: rdata <= cnt_t_r;
        ffb_pkg::ADR_CNT_B: rdata <= cnt_b_r;
        ffb_pkg::ADR_TIME: rdata <= ms_cnt_r;
        default: rdata <= 32'h0;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence scan_run;
    (state_r == ffb_pkg::FFB_SCAN) [*8];
  endsequence

  scan_len_a: assert property (
    tick |=> scan_run ##1 state_r == ffb_pkg::FFB_IDLE)
    else $error("scan does not visit eight stages");
  ms_step_a: assert property (
    tick |=> ms_cnt_r == $past(ms_cnt_r) + 32'h1)
    else $error("stamp clock did not step");
  ev_stamp_a: assert property (
    ev_vld |-> ev_o.stamp == ms_cnt_r && ev_o.chg != 3'h0)
    else $error("event stamp or change mask wrong");
  inst_pair_a: assert property (
    ev_vld && inst_r && ev_o.chg[0] && ev_o.val[0] |->
    ev_o.chg[1] && ev_o.val[1])
    else $error("instant start without trip");
  blk_excl_a: assert property (
    ev_vld |-> !(ev_o.val[ffb_pkg::O_START] && ev_o.val[ffb_pkg::O_BLK]))
    else $error("start and blocked together");
  stage_off_a: assert property (
    state_r == ffb_pkg::FFB_SCAN && !en_c && !force_act |=>
    !start_r[$past(idx_r)] && !trip_r[$past(idx_r)])
    else $error("disabled stage active");
  force_blk_a: assert property (
    state_r == ffb_pkg::FFB_SCAN && force_act &&
    fc_c == ffb_pkg::F_BLOCKED |=>
    blocked_r[$past(idx_r)] && !start_r[$past(idx_r)])
    else $error("forced block not shown");
  cnt_clear_a: assert property (
    clr_req |=> cnt_s_r <= 32'h1 && cnt_t_r <= 32'h1)
    else $error("counter clear ignored");
  trip_irq_a: assert property (
    ev_vld && ev_o.chg[1] && ev_o.val[1] && mask_r[1] |-> irq)
    else $error("trip did not raise interrupt");
  blk_sync_a: assert property (
    $changed(blk_lvl_r) |-> $past(blk_s2_r == blk_s3_r))
    else $error("block level moved without agreement");
  trip_delay_a: assert property (
    state_r == ffb_pkg::FFB_SCAN && t_n && !trip_r[idx_r] && !force_act &&
    dly_c != 21'h0 |-> tm_n >= dly_c ##1 trip_r[$past(idx_r)])
    else $error("delayed trip before its time");

endmodule

// ===== design/ffb_pkg.sv
// Constants, types and register map of the frequency stage block.
// Assumes one 20 MHz clock and a plain register port on the host side.
package ffb_pkg;

  // -------------------------------------------------------------------
  // Timing
  // -------------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int TS_RES_MS = 1;
  localparam int MS_CYCLES = CLK_HZ / 1000 * TS_RES_MS;
  localparam logic [3:0] MEAS_MS = 4'h5;

  // -------------------------------------------------------------------
  // Stages and settings
  // -------------------------------------------------------------------
  localparam int N_DIR = 4;
  localparam int N_STG = 2 * N_DIR;
  localparam int N_SG = 8;
  localparam int FREQ_LSB_MHZ = 10;
  localparam int HYST_MHZ = 20;
  localparam logic [15:0] HYST_UNITS = 16'(HYST_MHZ / FREQ_LSB_MHZ);
  localparam logic [15:0] PK_OVER_RST = 16'h13ec;
  localparam logic [15:0] PK_UNDER_RST = 16'h1324;
  localparam logic [20:0] DLY_RST = 21'h000064;
  localparam logic [2:0] NM_ON = 3'h1;
  localparam logic [2:0] NM_BLK = 3'h2;
  localparam logic [2:0] NM_TEST = 3'h3;
  localparam logic [2:0] NM_TBLK = 3'h4;
  localparam logic [2:0] NM_OFF = 3'h5;
  localparam logic [1:0] EN_NO = 2'h1;
  localparam logic [1:0] EN_YES = 2'h2;
  localparam logic [1:0] F_NORMAL = 2'h0;
  localparam logic [1:0] F_START = 2'h1;
  localparam logic [1:0] F_TRIP = 2'h2;
  localparam logic [1:0] F_BLOCKED = 2'h3;
  localparam int O_START = 0;
  localparam int O_TRIP = 1;
  localparam int O_BLK = 2;

  // -------------------------------------------------------------------
  // Register map
  // -------------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_EN = 8'h04;
  localparam logic [7:0] ADR_FORCE = 8'h08;
  localparam logic [7:0] ADR_SG_IDX = 8'h0c;
  localparam logic [7:0] ADR_SG_PK = 8'h10;
  localparam logic [7:0] ADR_SG_DLY = 8'h14;
  localparam logic [7:0] ADR_STATUS = 8'h18;
  localparam logic [7:0] ADR_IRQ_ST = 8'h1c;
  localparam logic [7:0] ADR_IRQ_MSK = 8'h20;
  localparam logic [7:0] ADR_CNT_S = 8'h24;
  localparam logic [7:0] ADR_CNT_T = 8'h28;
  localparam logic [7:0] ADR_CNT_B = 8'h2c;
  localparam logic [7:0] ADR_TIME = 8'h30;
  localparam int C_CLR = 16;
  localparam int PK_USE = 31;
  localparam logic [9:0] CTRL_RST = 10'h010;
  localparam logic [15:0] EN_RST = 16'h5555;
  localparam logic [15:0] FORCE_RST = 16'h0000;

  // -------------------------------------------------------------------
  // Types
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    FFB_IDLE = 2'b01,
    FFB_SCAN = 2'b10
  } ffb_state_t;

  typedef struct packed {
    logic [2:0] sg_sel;
    logic [2:0] node_mode;
    logic src_sel;
    logic force_en;
    logic allow_node;
    logic func_on;
  } ffb_ctrl_t;

  typedef struct packed {
    logic [2:0] stage;
    logic [2:0] chg;
    logic [2:0] val;
    logic [31:0] stamp;
  } ffb_event_t;

endpackage

// ===== bench/ffb_partner.sv
// Frequency front end and event sink facing the frequency stage block.
// Assumes the bench sets the wanted frequencies; records every event.
`timescale 1ns/1ps
module ffb_partner (
  input wire logic clk_sys, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic [15:0] f1_set, // Wanted first input frequency
  input wire logic [15:0] f2_set, // Wanted second input frequency
  output logic [15:0] freq1_hz, // First input frequency word
  output logic freq1_vld, // First input new word
  output logic [15:0] freq2_hz, // Second input frequency word
  output logic freq2_vld, // Second input new word
  input wire ffb_pkg::ffb_event_t ev_o, // Event record
  input wire logic ev_vld // Event pulse
);
  // -------------------------------------------------------------------
  // Measurement updates and event capture
  // -------------------------------------------------------------------
  ffb_pkg::ffb_event_t ev_q[$];
  logic [2:0] div_r;
  // New words every 8 cycles, well inside the staleness limit
  always_ff @(posedge clk_sys) begin
    div_r <= srst ? 3'h0 : div_r + 3'h1;
    freq1_vld <= !srst && div_r == 3'h7;
    freq2_vld <= !srst && div_r == 3'h3;
    freq1_hz <= f1_set;
    freq2_hz <= f2_set;
  end
  // Sink never stalls, every pulse is one record
  always @(posedge clk_sys) begin
    if (ev_vld === 1'b1) begin
      ev_q.push_back(ev_o);
    end
  end
endmodule

// ===== bench/ffb_top_tb.sv
// Self-checking bench for the frequency stage block.
// Assumes the partner model in ffb_partner.sv; 1 ms shortened to 20 cycles.
`timescale 1ns/1ps
module ffb_top_tb;
  // -------------------------------------------------------------------
  // Signals and instances
  // -------------------------------------------------------------------
  logic clk_sys = 1'b0, srst = 1'b1, blk_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rv, seed = 32'h51;
  logic wr_en = 1'b0, rd_en = 1'b0, ev_vld, irq;
  logic [15:0] f1 = 16'h1356, f2 = 16'h1356, fq1, fq2;
  logic v1, v2;
  logic [7:0] start_o, trip_o, blocked_o;
  ffb_pkg::ffb_event_t ev_o;
  int err_count = 0, n_compared = 0, cyc = 0, i, m;
  int modes[5] = '{1, 3, 5, 2, 4};
  // Shortened ms so the whole run stays a few thousand cycles
  ffb_top #(.MS_CYC(20)) uut (.clk_sys(clk_sys), .srst(srst),
    .freq1_hz(fq1), .freq1_vld(v1), .freq2_hz(fq2), .freq2_vld(v2),
    .blk_in(blk_in), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .start_o(start_o), .trip_o(trip_o),
    .blocked_o(blocked_o), .ev_o(ev_o), .ev_vld(ev_vld), .irq(irq));
  ffb_partner prt (.clk_sys(clk_sys), .srst(srst), .f1_set(f1),
    .f2_set(f2), .freq1_hz(fq1), .freq1_vld(v1), .freq2_hz(fq2),
    .freq2_vld(v2), .ev_o(ev_o), .ev_vld(ev_vld));
  always #25 clk_sys = ~clk_sys;
  // -------------------------------------------------------------------
  // Helpers: bus, waits, model and checks
  // -------------------------------------------------------------------
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask
  task cy(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp, input string s);
    rd(a, rv);
    chk(rv, exp, s);
  endtask
  // Looks for one record and empties the capture queue
  task ev_chk(input int st, input logic [2:0] c, input logic [2:0] v);
    logic hit;
    hit = 1'b0;
    foreach (prt.ev_q[k]) begin
      if (prt.ev_q[k].stage == st && (prt.ev_q[k].chg & c) == c &&
          (prt.ev_q[k].val & c) == v) hit = 1'b1;
    end
    prt.ev_q.delete();
    chk({31'h0, hit}, 32'h1, "event record");
  endtask
  // Over stage model: release needs the hysteresis margin
  function logic over_on(input int f, input int pk, input logic held);
    return held ? f > pk - 2 : f > pk;
  endfunction
  function logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Hang guard, generous for about 1700 expected cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      complete_run();
    end
  end
  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    rchk(ffb_pkg::ADR_CTRL, 32'h10, "ctrl reset");
    rchk(ffb_pkg::ADR_EN, 32'h5555, "enable reset");
    rchk(8'hfc, 32'h0, "unmapped read");
    wr(ffb_pkg::ADR_EN, 32'h566a);
    wr(ffb_pkg::ADR_SG_IDX, 32'h0);
    wr(ffb_pkg::ADR_SG_PK, 32'h80001388);
    wr(ffb_pkg::ADR_SG_DLY, 32'h0);
    wr(ffb_pkg::ADR_SG_IDX, 32'h4);
    wr(ffb_pkg::ADR_SG_PK, 32'h80001324);
    wr(ffb_pkg::ADR_SG_DLY, 32'h3);
    wr(ffb_pkg::ADR_SG_IDX, 32'h8);
    wr(ffb_pkg::ADR_SG_PK, 32'h80001450);
    wr(ffb_pkg::ADR_IRQ_MSK, 32'h7);
    f1 <= 16'h1389;
    cy(60);
    chk(start_o, 8'h0, "function off");
    $display("test off done");
    wr(ffb_pkg::ADR_CTRL, 32'h10011);
    cy(60);
    chk(start_o[0] & trip_o[0], 1'b1, "instant");
    ev_chk(0, 3'h3, 3'h3);
    chk(irq, 1'b1, "irq set");
    rchk(ffb_pkg::ADR_IRQ_ST, 32'h3, "irq status");
    rchk(ffb_pkg::ADR_CNT_S, 32'h1, "start count");
    rchk(ffb_pkg::ADR_CNT_T, 32'h1, "trip count");
    rd(ffb_pkg::ADR_TIME, rv);
    chk({31'h0, rv > 32'h2 && rv < 32'h20}, 32'h1, "ms count");
    wr(ffb_pkg::ADR_IRQ_ST, 32'h3);
    cy(2);
    chk(irq, 1'b0, "irq cleared");
    $display("test instant done");
    f1 <= 16'h1387;
    cy(60);
    chk(start_o[0], over_on(4999, 5000, 1'b1), "hyst hold");
    f1 <= 16'h1386;
    cy(60);
    chk(start_o[0], over_on(4998, 5000, 1'b1), "hyst drop");
    ev_chk(0, 3'h1, 3'h0);
    seed = xs(seed);
    f1 <= 16'h1389 + 16'(seed % 200);
    cy(60);
    chk(start_o[0], 1'b1, "random pick-up");
    f1 <= 16'h1356;
    wr(ffb_pkg::ADR_CTRL, 32'h91);
    f1 <= 16'h13ec;
    cy(60);
    chk(start_o[0], 1'b0, "group one below");
    f1 <= 16'h1451;
    cy(60);
    chk(start_o[0], 1'b1, "group one above");
    f1 <= 16'h12c0;
    wr(ffb_pkg::ADR_CTRL, 32'h11);
    for (i = 0; i < 200 && start_o[4] !== 1'b1; i++) cy(1);
    cy(25);
    chk(trip_o[4], 1'b0, "delay running");
    cy(40);
    chk(trip_o[4], 1'b1, "delay done");
    // Under stage holds until 20 mHz above its pick-up
    f1 <= 16'h1325;
    cy(60);
    chk(start_o[4], 1'b1, "under hyst hold");
    f1 <= 16'h1326;
    cy(60);
    chk(start_o[4], 1'b0, "under hyst drop");
    $display("test delay done");
    f1 <= 16'h1356;
    f2 <= 16'h1389;
    wr(ffb_pkg::ADR_CTRL, 32'h19);
    cy(60);
    chk(start_o, 8'h01, "second source");
    f2 <= 16'h1356;
    f1 <= 16'h1389;
    cy(60);
    chk(start_o, 8'h0, "second source low");
    // Node mode off is ignored while the node setting is not allowed
    wr(ffb_pkg::ADR_CTRL, 32'h51);
    cy(60);
    chk(start_o[0], 1'b1, "mode not allowed");
    for (i = 0; i < 5; i++) begin
      m = modes[i];
      wr(ffb_pkg::ADR_CTRL, 32'h3 | (m << 4));
      cy(60);
      chk(start_o[0], m == 1 || m == 3, "mode start");
      chk(blocked_o[0], m == 2 || m == 4, "mode block");
    end
    f1 <= 16'h1356;
    wr(ffb_pkg::ADR_CTRL, 32'h11);
    cy(60);
    @(posedge clk_sys);
    blk_in <= 1'b1;
    cy(30);
    f1 <= 16'h1389;
    cy(60);
    chk({blocked_o[0], start_o[0]}, 2'b10, "block input");
    @(posedge clk_sys);
    blk_in <= 1'b0;
    f1 <= 16'h1356;
    wr(ffb_pkg::ADR_FORCE, 32'h4);
    cy(60);
    chk(start_o[1], 1'b0, "force locked");
    wr(ffb_pkg::ADR_CTRL, 32'h15);
    for (i = 0; i < 4; i++) begin
      wr(ffb_pkg::ADR_FORCE, i << 2);
      cy(60);
      chk(start_o[1], i == 1 || i == 2, "force start");
      chk(trip_o[1], i == 2, "force trip");
      chk(blocked_o[1], i == 3, "force block");
    end
    $display("test modes done");
    complete_run();
  end
endmodule
